// *** src/adps_params.svh ***
// constants for the analog/digital pin share block
// assumes inclusion by bare name from the package and module
`ifndef ADPS_PARAMS_SVH
`define ADPS_PARAMS_SVH
`define ADPS_NUM_PINS 8
`define ADPS_NUM_ADCS 2
`define ADPS_NUM_FUNCS 4
`define ADPS_PCFG_RESET 1'h0
`define ADPS_PULLUP_RESET 1'h0
`define ADPS_DIR_RESET 1'h1
`endif

// *** src/adps_pkg.sv ***
// types for the analog/digital pin share block
// assumes adps_params.svh is on the include path
`default_nettype none
`include "adps_params.svh"
package adps_pkg;
   typedef struct packed {
      logic dir_in;
      logic out_val;
      logic pullup_en;
   } adps_port_cfg_t;
   typedef struct packed {
      logic in_buf_en;
      logic out_en;
      logic out_val;
      logic pullup_on;
   } adps_pad_ctl_t;
   typedef enum logic [1:0] {
      ADPS_OWN_ANALOG = 2'h0,
      ADPS_OWN_DIGITAL = 2'h1,
      ADPS_OWN_PERIPH = 2'h2
   } adps_owner_t;
endpackage
`default_nettype wire

// *** src/adps_pin_share.sv ***
// per-pin selection between analog input, multiplexed peripherals and port io
// assumes configuration comes from core_clk logic; pad input is asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "adps_params.svh"
// Behaviour
// - shared pins default analog after reset
// - analog pin disables digital input buffer
// - digital read of analog pin returns zero
// - digital only when every converter agrees
// - output driver usable while analog selected
// - fixed priority, lower functions inoperative
// - per-pin switchable weak pull-up
module adps_pin_share
   import adps_pkg::*;
#(
   parameter int NUM_PINS = `ADPS_NUM_PINS,
   parameter int NUM_ADCS = `ADPS_NUM_ADCS,
   parameter int NUM_FUNCS = `ADPS_NUM_FUNCS
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // converter pin configuration writes, one word per converter
   input wire logic [NUM_ADCS-1:0] pcfg_wr,
   input wire logic [NUM_ADCS-1:0][NUM_PINS-1:0] pcfg_wdata,
   // port configuration writes
   input wire logic port_wr,
   input wire adps_port_cfg_t [NUM_PINS-1:0] port_wdata,
   // peripheral functions, index 0 highest priority
   input wire logic [NUM_PINS-1:0][NUM_FUNCS-1:0] func_en,
   input wire logic [NUM_PINS-1:0][NUM_FUNCS-1:0] func_out,
   input wire logic [NUM_PINS-1:0][NUM_FUNCS-1:0] func_oe,
   // pads
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe,
   output logic [NUM_PINS-1:0] pad_in_buf_en,
   output logic [NUM_PINS-1:0] pad_pullup_en,
   // readback and ownership
   output logic [NUM_PINS-1:0] port_read,
   output logic [NUM_PINS-1:0] analog_sel,
   output logic [NUM_PINS-1:0][NUM_FUNCS-1:0] func_grant,
   output logic [NUM_ADCS-1:0][NUM_PINS-1:0] pcfg_read
);

   // refuse sizes the logic cannot serve
   if (NUM_PINS < 1 || NUM_ADCS < 1 || NUM_FUNCS < 1)
   begin : g_bad_size
      $error("adps_pin_share: sizes must be at least one");
   end

   // one-hot grant of the lowest-index enabled function
   function automatic logic [NUM_FUNCS-1:0] prio_grant(input logic [NUM_FUNCS-1:0] en);
      logic [NUM_FUNCS-1:0] g;
      logic taken;
      g = '0;
      taken = 1'b0;
      for (int i = 0; i < NUM_FUNCS; i++)
      begin
         if (en[i] && !taken)
         begin
            g[i] = 1'b1;
            taken = 1'b1;
         end
      end
      return g;
   endfunction

   logic [NUM_ADCS-1:0][NUM_PINS-1:0] pcfg;
   logic [NUM_ADCS-1:0][NUM_PINS-1:0] next_pcfg;
   adps_port_cfg_t [NUM_PINS-1:0] port_cfg;
   adps_port_cfg_t [NUM_PINS-1:0] next_port_cfg;
   logic [NUM_PINS-1:0] pad_sync1;
   logic [NUM_PINS-1:0] pad_sync2;
   logic [NUM_PINS-1:0] next_port_read;
   logic [NUM_PINS-1:0] digital_ok;
   adps_pad_ctl_t [NUM_PINS-1:0] pad_ctl;

   always_comb
   begin
      next_pcfg = pcfg;
      for (int a = 0; a < NUM_ADCS; a++)
      begin
         if (pcfg_wr[a])
         begin
            next_pcfg[a] = pcfg_wdata[a];
         end
      end
      next_port_cfg = port_cfg;
      if (port_wr)
      begin
         next_port_cfg = port_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pcfg <= '{default: '{default: `ADPS_PCFG_RESET}};
         for (int p = 0; p < NUM_PINS; p++)
         begin
            port_cfg[p] <= '{dir_in: `ADPS_DIR_RESET, out_val: 1'h0, pullup_en: `ADPS_PULLUP_RESET};
         end
      end
      else
      begin
         pcfg <= next_pcfg;
         port_cfg <= next_port_cfg;
      end
   end

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PINS; gp++)
      begin : g_pin
         logic [NUM_FUNCS-1:0] grant;
         logic periph;
         always_comb
         begin
            digital_ok[gp] = 1'b1;
            for (int a = 0; a < NUM_ADCS; a++)
            begin
               digital_ok[gp] = digital_ok[gp] & pcfg[a][gp];
            end
         end
         // analog outranks all peripheral functions
         assign grant = digital_ok[gp] ? prio_grant(func_en[gp]) : '0;
         assign periph = |grant;
         always_comb
         begin
            pad_ctl[gp].in_buf_en = digital_ok[gp];
            pad_ctl[gp].pullup_on = port_cfg[gp].pullup_en;
            if (periph)
            begin
               pad_ctl[gp].out_en = |(grant & func_oe[gp]);
               pad_ctl[gp].out_val = |(grant & func_out[gp]);
            end
            else
            begin
               // port driver works even while analog is selected
               pad_ctl[gp].out_en = !port_cfg[gp].dir_in;
               pad_ctl[gp].out_val = port_cfg[gp].out_val;
            end
         end
         assign func_grant[gp] = grant;
         assign pad_oe[gp] = pad_ctl[gp].out_en;
         assign pad_out[gp] = pad_ctl[gp].out_val;
         assign pad_in_buf_en[gp] = pad_ctl[gp].in_buf_en;
         assign pad_pullup_en[gp] = pad_ctl[gp].pullup_on;
         assign analog_sel[gp] = !digital_ok[gp];
         assign next_port_read[gp] = pad_sync2[gp] & digital_ok[gp];
      end
   endgenerate

   // two flops tame the asynchronous pad level before any logic reads it
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pad_sync1 <= '0;
         pad_sync2 <= '0;
         port_read <= '0;
      end
      else
      begin
         pad_sync1 <= pad_in;
         pad_sync2 <= pad_sync1;
         port_read <= next_port_read;
      end
   end

   assign pcfg_read = pcfg;

   // checks on pin 0 and the last pin stand for every pin
   chk_reset_analog: assert property (@(posedge core_clk) $rose(reset_n) |-> analog_sel == '1)
      else $error("pins not analog after reset");
   chk_reset_quiet: assert property (@(posedge core_clk) $rose(reset_n) |->
      (pcfg_read == '0 && pad_oe == '0 && pad_pullup_en == '0))
      else $error("configuration not at reset defaults");
   chk_buf_off: assert property (@(posedge core_clk) disable iff (!reset_n)
      ((analog_sel & pad_in_buf_en) | (pad_in_buf_en & ~pcfg_read[0])) == '0)
      else $error("input buffer on for analog pin");
   chk_read_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      analog_sel[0] |=> !port_read[0])
      else $error("analog pin read nonzero");
   chk_read_was_digital: assert property (@(posedge core_clk) disable iff (!reset_n)
      port_read[0] |-> !$past(analog_sel[0]))
      else $error("pin read high while analog");
   chk_write_lands: assert property (@(posedge core_clk) disable iff (!reset_n)
      ($past(reset_n) && $past(pcfg_wr[0])) |-> pcfg_read[0] == $past(pcfg_wdata[0]))
      else $error("converter configuration write lost");
   chk_all_adcs: assert property (@(posedge core_clk) disable iff (!reset_n)
      (pcfg_read[0][0] && !pcfg_read[NUM_ADCS-1][0]) |-> analog_sel[0])
      else $error("pin digital without every converter");
   chk_analog_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
      (analog_sel[NUM_PINS-1] && $past(port_wr) && !$past(port_wdata[NUM_PINS-1].dir_in)) |-> pad_oe[NUM_PINS-1])
      else $error("port driver lost under analog");
   chk_grant_onehot: assert property (@(posedge core_clk) disable iff (!reset_n)
      $onehot0(func_grant[0]) && (analog_sel[0] -> func_grant[0] == '0))
      else $error("priority grant wrong");
   chk_top_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!analog_sel[0] && func_en[0][0]) |-> func_grant[0][0])
      else $error("highest function not granted");
   chk_top_drives: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!analog_sel[0] && func_en[0][0]) |-> (pad_oe[0] == func_oe[0][0] && pad_out[0] == func_out[0][0]))
      else $error("top function does not own the pad");
   chk_pullup: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(port_wr) |-> pad_pullup_en[0] == $past(port_wdata[0].pullup_en))
      else $error("pull-up not following write");
   chk_pullup_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      ($past(reset_n) && !$past(port_wr)) |-> $stable(pad_pullup_en))
      else $error("pull-up changed without a write");

   // coverage of the main scenarios
   cov_digital: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(analog_sel[0]));
   cov_periph: cover property (@(posedge core_clk) disable iff (!reset_n) func_grant[0] != '0);
   cov_analog_out: cover property (@(posedge core_clk) disable iff (!reset_n) analog_sel[NUM_PINS-1] && pad_oe[NUM_PINS-1]);
   cov_reset_again: cover property (@(posedge core_clk) $rose(reset_n));
   cov_read_high: cover property (@(posedge core_clk) disable iff (!reset_n) port_read[0]);

endmodule
`default_nettype wire

// *** dv/adps_testbench.sv ***
// self-checking bench for the analog/digital pin share block
// assumes the design sources and adps_params.svh are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench
   import adps_pkg::*;
;
   logic core_clk = 1'h0;
   logic reset_n = 1'h0;
   logic [1:0] pcfg_wr = 2'h0;
   logic [1:0][7:0] pcfg_wdata = 16'h0000;
   logic port_wr = 1'h0;
   adps_port_cfg_t [7:0] port_wdata = 24'h924924;
   logic [7:0][3:0] func_en = 32'h0, func_out = 32'h0, func_oe = 32'h0;
   logic [7:0] pad_in = 8'h00;
   logic [7:0] pad_out, pad_oe, pad_in_buf_en, pad_pullup_en, port_read, analog_sel;
   logic [7:0][3:0] func_grant;
   logic [1:0][7:0] pcfg_read;
   int num_errors = 0;
   int tests_run = 0;
   always #20 core_clk = ~core_clk;
   adps_pin_share u_adps_pin_share (.core_clk(core_clk), .reset_n(reset_n), .pcfg_wr(pcfg_wr),
      .pcfg_wdata(pcfg_wdata), .port_wr(port_wr), .port_wdata(port_wdata), .func_en(func_en),
      .func_out(func_out), .func_oe(func_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_in_buf_en(pad_in_buf_en), .pad_pullup_en(pad_pullup_en), .port_read(port_read),
      .analog_sel(analog_sel), .func_grant(func_grant), .pcfg_read(pcfg_read));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic wr_pcfg(input logic [1:0] which, input logic [15:0] data);
      @(posedge core_clk);
      pcfg_wr <= which;
      pcfg_wdata <= data;
      @(posedge core_clk);
      pcfg_wr <= 2'h0;
   endtask
   task automatic test_reset_analog();
      @(posedge core_clk);
      pad_in <= 8'hFF;
      settle(4);
      check(32'(analog_sel), 32'hFF);
      check(32'(pcfg_read), 32'h0000);
      check(32'(pad_in_buf_en), 32'h00);
      check(32'(port_read), 32'h00);
      check(32'({pad_oe, pad_pullup_en}), 32'h0000);
      $display("test reset_analog done");
   endtask
   task automatic test_both_adcs();
      wr_pcfg(2'h1, 16'h000F);
      settle(4);
      check(32'(analog_sel), 32'hFF);
      check(32'(port_read), 32'h00);
      wr_pcfg(2'h2, 16'h0500);
      settle(0);
      check(32'(analog_sel), 32'hFA);
      check(32'(pad_in_buf_en), 32'h05);
      check(32'(pcfg_read), 32'h050F);
      settle(4);
      check(32'(port_read), 32'h05);
      $display("test both_adcs done");
   endtask
   task automatic test_port_drive();
      @(posedge core_clk);
      port_wr <= 1'h1;
      port_wdata <= 24'h52492C;
      @(posedge core_clk);
      port_wr <= 1'h0;
      settle(0);
      check(32'(pad_oe), 32'h80);
      check(32'(pad_out[7]), 32'h1);
      check(32'(analog_sel[7]), 32'h1);
      check(32'(pad_pullup_en), 32'h02);
      $display("test port_drive done");
   endtask
   task automatic test_priority();
      for (int k = 0; k < 4; k++)
      begin
         @(posedge core_clk);
         func_en[0] <= 4'hF << k;
         func_en[1] <= 4'hF;
         func_oe[0] <= 4'hF;
         func_out[0] <= 4'hA;
         settle(0);
         check(32'(func_grant[0]), 32'(4'h1 << k));
         check(32'({pad_oe[0], pad_out[0]}), 32'({1'h1, k[0]}));
         check(32'(func_grant[1]), 32'h0);
      end
      $display("test priority done");
   endtask
   task automatic test_mid_reset();
      @(posedge core_clk);
      reset_n <= 1'h0;
      settle(1);
      check(32'(analog_sel), 32'hFF);
      @(posedge core_clk);
      reset_n <= 1'h1;
      settle(0);
      check(32'(analog_sel), 32'hFF);
      check(32'(pcfg_read), 32'h0000);
      check(32'({pad_oe, pad_in_buf_en, pad_pullup_en}), 32'h000000);
      check(func_grant, 32'h0);
      settle(2);
      check(32'(port_read), 32'h00);
      check(32'(analog_sel), 32'hFF);
      $display("test mid_reset done");
   endtask
   task automatic close_out();
      $display("tests %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'h1;
      test_reset_analog();
      test_both_adcs();
      test_port_drive();
      test_priority();
      test_mid_reset();
      close_out();
   end
endmodule
`default_nettype wire
